//--- inc/thermal_alarm_pkg.sv
// constants for the thermal alarm and register select block
package thermal_alarm_pkg;
    // register selector codes
    localparam logic [1:0] SEL_MEASURED = 2'h0;
    localparam logic [1:0] SEL_SETTINGS = 2'h1;
    localparam logic [1:0] SEL_LOWER = 2'h2;
    localparam logic [1:0] SEL_UPPER = 2'h3;
    localparam int SEL_LOW_MSB = 1;
    localparam int SEL_HIGH_LSB = 2;
    localparam int SEL_WIDTH = 8;
    localparam logic [5:0] SEL_HIGH_ZERO = 6'h00;
    localparam logic [1:0] SEL_RESET = 2'h0;

    // settings register fields
    localparam int SET_SHUTDOWN = 0;
    localparam int SET_MODE = 1;
    localparam int SET_LEVEL = 2;
    localparam int SET_FT_LOW = 3;
    localparam int SET_FT_HIGH = 4;
    localparam int SET_KEPT = 5;
    localparam logic [4:0] SETTINGS_RESET = 5'h00;
    localparam logic [10:0] SETTINGS_PAD = 11'h000;

    // temperature words
    localparam int WORD_WIDTH = 16;
    localparam int TEMP_WIDTH = 9;
    localparam int TEMP_LSB = 7;
    localparam logic [6:0] TEMP_UNUSED = 7'h00;
    localparam logic [15:0] MEASURED_RESET = 16'h0000;
    localparam logic [15:0] LOWER_RESET = 16'h4B00;
    localparam logic [15:0] UPPER_RESET = 16'h5000;

    // consecutive fault counts per tolerance code
    localparam logic [2:0] FAULTS_CODE0 = 3'h1;
    localparam logic [2:0] FAULTS_CODE1 = 3'h2;
    localparam logic [2:0] FAULTS_CODE2 = 3'h4;
    localparam logic [2:0] FAULTS_CODE3 = 3'h6;
    localparam logic [2:0] FAULTS_ZERO = 3'h0;
    localparam logic [2:0] FAULTS_STEP = 3'h1;

    // which trip point is armed
    typedef enum logic [1:0] {
        WATCH_UPPER = 2'b00,
        WATCH_LOWER = 2'b01
    } watch_e;
endpackage : thermal_alarm_pkg

//--- src/thermal_alarm_and_register_select.sv
// thermal alarm, fault filter, shutdown sequencing and register select
// Summary of operation
// - interrupt mode: alarm first asserts after enough consecutive conversions above upper trip
// - interrupt mode: only shutdown entry or a completed register read clears alarm
// - after a clear, alarm reasserts after enough consecutive conversions below lower trip
// - interrupt events alternate upper, clear, lower, clear; armed threshold toggles
// - an uncleared interrupt alarm stays asserted whatever temperatures follow
// - both modes count consecutive faulting conversions and act at the tolerance
// - tolerance field bits 4:3 give 1, 2, 4 or 6 consecutive faults
// - tolerance bits reset to zero, one fault by default
// - shutdown finishes and stores the running conversion, then stands by
// - shutdown entry clears alarm in interrupt mode, keeps it in comparator mode
// - serial access works in shutdown; clearing shutdown resumes conversions
// - measured and trip values are nine-bit two's complement words
// - top bit of the temperature word is the sign
// - one code step is half a degree
// - selector bits 7:2 must be zero; a one there aborts the operation
// - selector low bits choose measured, settings, lower or upper register
// - selector holds its value between transactions
// - selector resets to zero, measured register selected
// - all registers reachable at any time, also during conversions
// - mode bit zero is comparator, one is interrupt
// - readable temperature updates only outside reads; fault checks always use new data
// - alarm active low after reset; level bit changes active state
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_and_register_select
    import thermal_alarm_pkg::*;
(
    // core clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // converter side, core clock
    input wire logic conv_done_i,
    input wire logic [TEMP_WIDTH-1:0] conv_data_i,
    input wire logic conv_busy_i,
    output logic conv_enable_o,
    output logic standby_o,
    // alarm pin, open drain
    output logic alarm_out_o,
    output logic alarm_oe_o,
    // serial link side, link clock
    input wire logic link_clk_i,
    input wire logic ptr_wr_i,
    input wire logic [SEL_WIDTH-1:0] ptr_data_i,
    input wire logic reg_wr_i,
    input wire logic [WORD_WIDTH-1:0] reg_wdata_i,
    input wire logic rd_active_i,
    input wire logic rd_done_i,
    output logic [WORD_WIDTH-1:0] rd_data_o,
    output logic abort_o
);
    // ---------------- link domain ----------------
    logic [1:0] sel_r;
    logic [4:0] l_settings_r;
    logic [WORD_WIDTH-1:0] l_lower_r;
    logic [WORD_WIDTH-1:0] l_upper_r;
    logic [WORD_WIDTH-1:0] l_measured_r;
    logic wr_tgl_r;
    logic rd_tgl_r;
    logic [2:0] tmp_sync_r;
    logic ptr_bad;
    // core-side measured word and its toggle, read by the link fetch below
    logic [WORD_WIDTH-1:0] c_measured_r;
    logic tmp_tgl_r;

    assign ptr_bad = ptr_data_i[SEL_WIDTH-1:SEL_HIGH_LSB] != SEL_HIGH_ZERO;

    // selector: held between transactions, bad high bits abort
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_r <= SEL_RESET;
            abort_o <= 1'b0;
        end
        else
        begin
            abort_o <= ptr_wr_i && ptr_bad;
            if (ptr_wr_i && !ptr_bad)
                sel_r <= ptr_data_i[SEL_LOW_MSB:0];
        end
    end

    // writable registers, measured register is read only
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            l_settings_r <= SETTINGS_RESET;
            l_lower_r <= LOWER_RESET;
            l_upper_r <= UPPER_RESET;
            wr_tgl_r <= 1'b0;
        end
        else if (reg_wr_i && sel_r != SEL_MEASURED)
        begin
            wr_tgl_r <= !wr_tgl_r;
            case (sel_r)
                SEL_SETTINGS: l_settings_r <= reg_wdata_i[SET_KEPT-1:0];
                SEL_LOWER: l_lower_r <= {reg_wdata_i[WORD_WIDTH-1:TEMP_LSB], TEMP_UNUSED};
                SEL_UPPER: l_upper_r <= {reg_wdata_i[WORD_WIDTH-1:TEMP_LSB], TEMP_UNUSED};
                default: l_settings_r <= l_settings_r;
            endcase
        end
    end

    // completed reads are passed to the core as toggles
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_tgl_r <= 1'b0;
        else if (rd_done_i)
            rd_tgl_r <= !rd_tgl_r;
    end

    // fetch new measured words, never while a read runs
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tmp_sync_r <= 3'b000;
            l_measured_r <= MEASURED_RESET;
        end
        else
        begin
            tmp_sync_r <= {tmp_sync_r[1:0], tmp_tgl_r};
            if ((tmp_sync_r[2] ^ tmp_sync_r[1]) && !rd_active_i)
                l_measured_r <= c_measured_r;
        end
    end

    // read data for the selected register
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_data_o <= MEASURED_RESET;
        else
            case (sel_r)
                SEL_MEASURED: rd_data_o <= l_measured_r;
                SEL_SETTINGS: rd_data_o <= {SETTINGS_PAD, l_settings_r};
                SEL_LOWER: rd_data_o <= l_lower_r;
                SEL_UPPER: rd_data_o <= l_upper_r;
                default: rd_data_o <= MEASURED_RESET;
            endcase
    end

    // ---------------- core domain ----------------
    logic [2:0] wr_sync_r;
    logic [2:0] rd_sync_r;
    logic [1:0] busy_sync_r;
    logic [4:0] settings_r;
    logic [WORD_WIDTH-1:0] lower_r;
    logic [WORD_WIDTH-1:0] upper_r;
    logic shutdown_prev_r;
    logic alarm_r;
    logic [2:0] fault_cnt_r;
    watch_e watch_r;
    logic mode_int;
    logic shutdown;
    logic sd_entry;
    logic read_clear;
    logic eval;
    logic fault;
    logic hit;
    logic [2:0] need;

    assign mode_int = settings_r[SET_MODE];
    assign shutdown = settings_r[SET_SHUTDOWN];
    assign sd_entry = shutdown && !shutdown_prev_r;
    assign read_clear = rd_sync_r[2] ^ rd_sync_r[1];

    // required consecutive faults from the tolerance field
    always_comb
    begin
        case (settings_r[SET_FT_HIGH:SET_FT_LOW])
            2'b00: need = FAULTS_CODE0;
            2'b01: need = FAULTS_CODE1;
            2'b10: need = FAULTS_CODE2;
            default: need = FAULTS_CODE3;
        endcase
    end

    // signed compare against the armed trip point, nine msbs only
    always_comb
    begin
        if (watch_r == WATCH_UPPER)
            fault = $signed(conv_data_i) > $signed(upper_r[WORD_WIDTH-1:TEMP_LSB]);
        else
            fault = $signed(conv_data_i) < $signed(lower_r[WORD_WIDTH-1:TEMP_LSB]);
    end

    // a pending interrupt alarm freezes evaluation until cleared
    assign eval = conv_done_i && !(mode_int && alarm_r);
    assign hit = eval && fault && (fault_cnt_r + FAULTS_STEP == need);

    // crossings from the link
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_sync_r <= 3'b000;
            rd_sync_r <= 3'b000;
            busy_sync_r <= 2'b00;
        end
        else
        begin
            wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
            rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
            busy_sync_r <= {busy_sync_r[0], rd_active_i};
        end
    end

    // core copies of the writable registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            settings_r <= SETTINGS_RESET;
            lower_r <= LOWER_RESET;
            upper_r <= UPPER_RESET;
            shutdown_prev_r <= 1'b0;
        end
        else
        begin
            shutdown_prev_r <= shutdown;
            if (wr_sync_r[2] ^ wr_sync_r[1])
            begin
                settings_r <= l_settings_r;
                lower_r <= l_lower_r;
                upper_r <= l_upper_r;
            end
        end
    end

    // measured word, half degree per step, held during reads
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            c_measured_r <= MEASURED_RESET;
            tmp_tgl_r <= 1'b0;
        end
        else if (conv_done_i && !busy_sync_r[1])
        begin
            c_measured_r <= {conv_data_i, TEMP_UNUSED};
            tmp_tgl_r <= !tmp_tgl_r;
        end
    end

    // converter run and standby indication
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            conv_enable_o <= 1'b0;
            standby_o <= 1'b0;
        end
        else
        begin
            conv_enable_o <= !shutdown;
            standby_o <= shutdown && !conv_busy_i;
        end
    end

    // armed threshold flips on each event
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            watch_r <= WATCH_UPPER;
        else if (hit)
            watch_r <= (watch_r == WATCH_UPPER) ? WATCH_LOWER : WATCH_UPPER;
    end

    // consecutive fault counter
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fault_cnt_r <= FAULTS_ZERO;
        else if (hit)
            fault_cnt_r <= FAULTS_ZERO;
        else if (eval)
            fault_cnt_r <= fault ? fault_cnt_r + FAULTS_STEP : FAULTS_ZERO;
    end

    // alarm state: trip events win, read or shutdown clears only in interrupt mode
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            alarm_r <= 1'b0;
        else if (hit)
            alarm_r <= mode_int ? 1'b1 : (watch_r == WATCH_UPPER);
        else if (mode_int && (read_clear || sd_entry))
            alarm_r <= 1'b0;
    end

    // open-drain pin: pulled low while the pin reads low
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alarm_out_o <= 1'b0;
            alarm_oe_o <= 1'b0;
        end
        else
        begin
            alarm_out_o <= 1'b0;
            alarm_oe_o <= alarm_r ^ settings_r[SET_LEVEL];
        end
    end

    // ---------------- checks ----------------
    sequence s_int_pending;
        mode_int && alarm_r;
    endsequence

    sequence s_read_seen;
        read_clear && !sd_entry;
    endsequence

    a_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_int_pending ##0 s_read_seen |=> !alarm_r)
        else $error("read did not clear interrupt alarm");

    a_sd_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_int_pending ##0 sd_entry |=> !alarm_r)
        else $error("shutdown entry did not clear interrupt alarm");

    a_cmp_sd_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mode_int && sd_entry && !conv_done_i |=> $stable(alarm_r))
        else $error("shutdown changed comparator alarm");

    a_pending_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_int_pending ##0 (!read_clear && !sd_entry && $stable(settings_r)) |=> alarm_r)
        else $error("interrupt alarm dropped without a clear");

    a_fault_filter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(alarm_r) |-> $past(fault_cnt_r) + FAULTS_STEP == $past(need))
        else $error("alarm rose before tolerance reached");

    a_watch_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_int && $rose(alarm_r) |-> watch_r != $past(watch_r))
        else $error("armed threshold did not toggle");

    a_count_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        eval && !fault |=> fault_cnt_r == FAULTS_ZERO)
        else $error("fault counter kept counting after pass");

    a_read_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        busy_sync_r[1] |=> $stable(c_measured_r))
        else $error("measured word changed during read");

    a_shutdown_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        shutdown ##1 shutdown |-> !conv_enable_o)
        else $error("converter still enabled in shutdown");

    a_pin_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(alarm_r) && $stable(settings_r) |=> alarm_oe_o != $past(alarm_oe_o))
        else $error("alarm pin did not follow alarm state");

    a_abort_ptr: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        ptr_wr_i && ptr_bad |=> abort_o && $stable(sel_r))
        else $error("bad selector not aborted");
endmodule : thermal_alarm_and_register_select
`default_nettype wire

//--- verification/link_master.sv
// far-side two-wire master model driving the link register port
`timescale 1ns/1ps
`default_nettype none
module link_master
(
    // link clock and requests
    output logic link_clk_o,
    output logic ptr_wr_o,
    output logic [7:0] ptr_data_o,
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o,
    output logic rd_active_o,
    output logic rd_done_o,
    // answers from the device
    input wire logic [15:0] rd_data_i,
    input wire logic abort_i
);
    logic aborted;
    // parked link: clock low, nothing requested
    initial
    begin
        link_clk_o = 1'b0;
        ptr_wr_o = 1'b0;
        ptr_data_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
        rd_active_o = 1'b0;
        rd_done_o = 1'b0;
        aborted = 1'b0;
    end
    // one link period; the clock only runs inside a transfer
    task automatic tick();
        #15 link_clk_o = 1'b1;
        #1;
        if (abort_i === 1'b1)
            aborted = 1'b1;
        #14 link_clk_o = 1'b0;
    endtask : tick
    // selector byte write; released data shows its inverse
    task automatic set_ptr(input logic [7:0] v);
        ptr_data_o = v;
        ptr_wr_o = 1'b1;
        tick();
        ptr_wr_o = 1'b0;
        ptr_data_o = ~v;
        tick();
    endtask : set_ptr
    // word write to the selected register
    task automatic write_reg(input logic [15:0] v);
        reg_wdata_o = v;
        reg_wr_o = 1'b1;
        tick();
        reg_wr_o = 1'b0;
        reg_wdata_o = ~v;
        tick();
    endtask : write_reg
    // read of the selected register, idle lead-in lets new data cross
    task automatic read_cur(output logic [15:0] d);
        repeat (6) tick();
        rd_active_o = 1'b1;
        repeat (2) tick();
        d = rd_data_i;
        rd_done_o = 1'b1;
        tick();
        rd_done_o = 1'b0;
        rd_active_o = 1'b0;
        tick();
    endtask : read_cur
    // point first, upper selector bits kept zero, then read
    task automatic read_reg(input logic [1:0] sel, output logic [15:0] d);
        set_ptr({6'h00, sel});
        read_cur(d);
    endtask : read_reg
endmodule : link_master
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the thermal alarm and register select block
`timescale 1ns/1ps
`default_nettype none
module tb
    import thermal_alarm_pkg::*;
;
    logic clk, rst_n, conv_done, conv_busy, conv_enable, standby, alarm_out, alarm_oe;
    logic link_clk, ptr_wr, reg_wr, rd_active, rd_done, abort;
    logic [8:0] conv_data;
    logic [7:0] ptr_data;
    logic [15:0] reg_wdata, rd_data, d;
    logic [8:0] fmt [3] = '{9'h001, 9'h0FA, 9'h192};
    logic fmt_pin [3] = '{1'b1, 1'b0, 1'b1};
    logic [2:0] need [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    int mismatches = 0;
    int compares = 0;
    // open-drain alarm pin with its pull-up
    wire logic pin = alarm_oe ? alarm_out : 1'b1;
    thermal_alarm_and_register_select dut
    (
        .clk_i(clk),
        .rst_n_i(rst_n),
        .conv_done_i(conv_done),
        .conv_data_i(conv_data),
        .conv_busy_i(conv_busy),
        .conv_enable_o(conv_enable),
        .standby_o(standby),
        .alarm_out_o(alarm_out),
        .alarm_oe_o(alarm_oe),
        .link_clk_i(link_clk),
        .ptr_wr_i(ptr_wr),
        .ptr_data_i(ptr_data),
        .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata),
        .rd_active_i(rd_active),
        .rd_done_i(rd_done),
        .rd_data_o(rd_data),
        .abort_o(abort)
    );
    link_master master
    (
        .link_clk_o(link_clk),
        .ptr_wr_o(ptr_wr),
        .ptr_data_o(ptr_data),
        .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata),
        .rd_active_o(rd_active),
        .rd_done_o(rd_done),
        .rd_data_i(rd_data),
        .abort_i(abort)
    );
    // core clock, 8 ns
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic flag(input string what, input logic exp, input logic got);
        check(what, {15'h0000, exp}, {15'h0000, got});
    endtask : flag
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // reset both domains, link clock pulsed twice meanwhile
    task automatic reset_dut();
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        master.tick();
        master.tick();
        rst_n = 1'b1;
        @(negedge clk);
    endtask : reset_dut
    // point and write, then give the core time to take the copy
    task automatic put(input logic [1:0] sel, input logic [15:0] v);
        master.set_ptr({6'h00, sel});
        master.write_reg(v);
        repeat (10) @(negedge clk);
    endtask : put
    task automatic get(input logic [1:0] sel, input logic [15:0] exp, input string what);
        master.read_reg(sel, d);
        check(what, exp, d);
        repeat (10) @(negedge clk);
    endtask : get
    task automatic finish_conv(input logic [8:0] t);
        conv_data = t;
        conv_done = 1'b1;
        conv_busy = 1'b0;
        @(negedge clk);
        conv_done = 1'b0;
        conv_data = ~t;
        repeat (6) @(negedge clk);
    endtask : finish_conv
    task automatic convert(input logic [8:0] t);
        conv_busy = 1'b1;
        repeat (3) @(negedge clk);
        finish_conv(t);
    endtask : convert
    task automatic rd_clear();
        master.read_cur(d);
        repeat (10) @(negedge clk);
    endtask : rd_clear
    // watchdog sized well beyond the expected run
    initial
    begin
        #400000;
        mismatches++;
        summarize();
    end
    // test sequence
    initial
    begin
        conv_done = 1'b0;
        conv_busy = 1'b0;
        conv_data = 9'h000;
        reset_dut();
        flag("alarm pin", 1'b1, pin);
        master.read_cur(d);
        check("default selector", MEASURED_RESET, d);
        get(SEL_SETTINGS, 16'h0000, "settings");
        get(SEL_LOWER, 16'h4B00, "lower");
        get(SEL_UPPER, 16'h5000, "upper");
        master.read_cur(d);
        check("reread upper", 16'h5000, d);
        $display("reset test done");
        put(SEL_UPPER, 16'h1234);
        get(SEL_UPPER, 16'h1200, "upper");
        put(SEL_MEASURED, 16'h5555);
        get(SEL_MEASURED, 16'h0000, "measured");
        for (int i = 2; i < 8; i++)
        begin
            master.aborted = 1'b0;
            master.set_ptr(8'h03 | (8'h01 << i));
            master.read_cur(d);
            flag("abort", 1'b1, master.aborted);
            check("kept selector", 16'h0000, d);
        end
        $display("selector test done");
        for (int i = 0; i < 3; i++)
        begin
            convert(fmt[i]);
            get(SEL_MEASURED, {fmt[i], 7'h00}, "measured");
            flag("alarm pin", fmt_pin[i], pin);
        end
        $display("format test done");
        put(SEL_UPPER, 16'h1900);
        put(SEL_LOWER, 16'h1800);
        for (int c = 0; c < 4; c++)
        begin
            put(SEL_SETTINGS, {11'h000, c[1:0], 3'h0});
            get(SEL_SETTINGS, {11'h000, c[1:0], 3'h0}, "settings");
            repeat (need[c] - 3'h1) convert(9'h033);
            convert(9'h031);
            repeat (need[c] - 3'h1) convert(9'h033);
            flag("alarm pin", 1'b1, pin);
            convert(9'h033);
            flag("alarm pin", 1'b0, pin);
            repeat (need[c] - 3'h1) convert(9'h02F);
            flag("alarm pin", 1'b0, pin);
            convert(9'h02F);
            flag("alarm pin", 1'b1, pin);
        end
        $display("filter test done");
        reset_dut();
        put(SEL_SETTINGS, 16'h0002);
        convert(9'h0B0);
        flag("alarm pin", 1'b0, pin);
        convert(9'h090);
        convert(9'h0B0);
        flag("alarm pin", 1'b0, pin);
        rd_clear();
        flag("alarm pin", 1'b1, pin);
        convert(9'h0B0);
        flag("alarm pin", 1'b1, pin);
        convert(9'h090);
        flag("alarm pin", 1'b0, pin);
        rd_clear();
        convert(9'h0B0);
        flag("alarm pin", 1'b0, pin);
        put(SEL_SETTINGS, 16'h0003);
        flag("alarm pin", 1'b1, pin);
        flag("conv enable", 1'b0, conv_enable);
        flag("standby", 1'b1, standby);
        put(SEL_SETTINGS, 16'h0002);
        flag("conv enable", 1'b1, conv_enable);
        $display("interrupt test done");
        reset_dut();
        put(SEL_SETTINGS, 16'h0000);
        convert(9'h0B0);
        flag("alarm pin", 1'b0, pin);
        conv_busy = 1'b1;
        put(SEL_SETTINGS, 16'h0001);
        flag("standby", 1'b0, standby);
        finish_conv(9'h0C0);
        flag("standby", 1'b1, standby);
        flag("alarm pin", 1'b0, pin);
        get(SEL_MEASURED, {9'h0C0, 7'h00}, "measured");
        put(SEL_SETTINGS, 16'h0005);
        flag("alarm pin", 1'b1, pin);
        $display("shutdown test done");
        summarize();
    end
endmodule : tb
`default_nettype wire
